/* File: src/epc_pkg.sv */
`default_nettype none
package epc_pkg;
   // ==========================================================
   // link framing
   localparam logic [3:0] BITS_FOUR_WIRE  = 4'h8;
   localparam logic [3:0] BITS_THREE_WIRE = 4'h9;
   // ==========================================================
   // gate driving level command
   localparam logic [7:0] CMD_GATE_LEVEL     = 8'h03;
   localparam logic [4:0] GATE_CODE_DEFAULT  = 5'h00;
   localparam logic [4:0] GATE_CODE_MIN      = 5'h03;
   localparam logic [4:0] GATE_CODE_MAX      = 5'h17;
   localparam logic [5:0] GATE_HALF_V_DEFAULT = 6'h28;
   localparam logic [5:0] GATE_HALF_V_OFFSET  = 6'h11;
   // ==========================================================
   // reset values and parameter index limit
   localparam logic [7:0] CMD_RESET       = 8'h00;
   localparam logic [7:0] PARAM_IDX_RESET = 8'h00;
   localparam logic [7:0] PARAM_IDX_MAX   = 8'hff;
endpackage : epc_pkg
`default_nettype wire

/* File: src/epc_host_cmd_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - link bits are taken only while chip select is low; select high clears the bit counter.
// - a byte with data/command low is a command code, with it high a parameter byte.
// - the device is held in reset while the reset pin is low and runs while it is high.
// - busy is high while internal work (waveform output, sensor talk) is going on, else low.
// - strap low selects the 4-line link with a data/command pin, high the 3-line 9-bit link.
// - command 03h takes one parameter whose low five bits, when 00h or 03h to 17h, set the gate high level.
module epc_host_cmd_port (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       link_clk_in,
   input  wire logic       link_data_in,
   input  wire logic       link_cs_low_in,
   input  wire logic       link_dc_in,
   input  wire logic       reset_low_pin_in,
   input  wire logic       link_variant_strap_in,
   input  wire logic       work_in,
   output logic            busy_out,
   output logic            three_wire_out,
   output logic            cmd_valid_out,
   output logic [7:0]      cmd_code_out,
   output logic            param_valid_out,
   output logic [7:0]      param_data_out,
   output logic [7:0]      param_index_out,
   output logic [4:0]      gate_high_level_out,
   output logic [5:0]      gate_half_volts_out
);

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] cs_s;
      logic [1:0] dc_s;
      logic [1:0] rstp_s;
      logic [1:0] work_s;
      logic [1:0] strap_s;
      logic       scl_prev;
      logic       three_wire;
      logic [3:0] bit_cnt;
      logic [8:0] shift;
      logic       busy;
      logic       cmd_valid;
      logic [7:0] cmd_code;
      logic       param_valid;
      logic [7:0] param_data;
      logic [7:0] param_index;
      logic [4:0] gate_code;
      logic [5:0] gate_half_v;
   } epc_state_t;

   epc_state_t s;
   epc_state_t next_s;

   // ==========================================================
   // next state
   always_comb
   begin
      logic [8:0] sh;
      logic [3:0] last;
      logic       is_data;
      sh      = 9'h000;
      last    = 4'h0;
      is_data = 1'b0;
      next_s  = s;
      // second stage is the only reader of each first stage
      next_s.scl_s   = {s.scl_s[0], link_clk_in};
      next_s.sda_s   = {s.sda_s[0], link_data_in};
      next_s.cs_s    = {s.cs_s[0], link_cs_low_in};
      next_s.dc_s    = {s.dc_s[0], link_dc_in};
      next_s.rstp_s  = {s.rstp_s[0], reset_low_pin_in};
      next_s.work_s  = {s.work_s[0], work_in};
      next_s.strap_s = {s.strap_s[0], link_variant_strap_in};
      next_s.scl_prev    = s.scl_s[1];
      next_s.cmd_valid   = 1'b0;
      next_s.param_valid = 1'b0;
      next_s.busy        = s.work_s[1];
      if (!s.rstp_s[1])
      begin
         next_s.bit_cnt     = 4'h0;
         next_s.cmd_code    = epc_pkg::CMD_RESET;
         next_s.param_index = epc_pkg::PARAM_IDX_RESET;
         next_s.gate_code   = epc_pkg::GATE_CODE_DEFAULT;
         next_s.gate_half_v = epc_pkg::GATE_HALF_V_DEFAULT;
         next_s.three_wire  = s.strap_s[1];
      end
      else if (s.cs_s[1])
      begin
         // strap only takes effect between frames, never mid byte
         next_s.bit_cnt    = 4'h0;
         next_s.three_wire = s.strap_s[1];
      end
      else if (s.scl_s[1] && !s.scl_prev)
      begin
         sh           = {s.shift[7:0], s.sda_s[1]};
         next_s.shift = sh;
         last = s.three_wire ? (epc_pkg::BITS_THREE_WIRE - 4'h1)
                             : (epc_pkg::BITS_FOUR_WIRE - 4'h1);
         if (s.bit_cnt == last)
         begin
            next_s.bit_cnt = 4'h0;
            is_data = s.three_wire ? sh[8] : s.dc_s[1];
            if (!is_data)
            begin
               next_s.cmd_valid   = 1'b1;
               next_s.cmd_code    = sh[7:0];
               next_s.param_index = epc_pkg::PARAM_IDX_RESET;
            end
            else
            begin
               next_s.param_valid = 1'b1;
               next_s.param_data  = sh[7:0];
               if (s.param_index != epc_pkg::PARAM_IDX_MAX)
               begin
                  next_s.param_index = s.param_index + 8'h01;
               end
               // reserved codes leave the level unchanged
               if (s.cmd_code == epc_pkg::CMD_GATE_LEVEL &&
                   s.param_index == epc_pkg::PARAM_IDX_RESET)
               begin
                  if (sh[4:0] == epc_pkg::GATE_CODE_DEFAULT)
                  begin
                     next_s.gate_code   = sh[4:0];
                     next_s.gate_half_v = epc_pkg::GATE_HALF_V_DEFAULT;
                  end
                  else if (sh[4:0] >= epc_pkg::GATE_CODE_MIN &&
                           sh[4:0] <= epc_pkg::GATE_CODE_MAX)
                  begin
                     next_s.gate_code   = sh[4:0];
                     next_s.gate_half_v = {1'b0, sh[4:0]} + epc_pkg::GATE_HALF_V_OFFSET;
                  end
               end
            end
         end
         else
         begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s             <= '0;
         s.cs_s        <= 2'h3;
         s.gate_half_v <= epc_pkg::GATE_HALF_V_DEFAULT;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign busy_out            = s.busy;
   assign three_wire_out      = s.three_wire;
   assign cmd_valid_out       = s.cmd_valid;
   assign cmd_code_out        = s.cmd_code;
   assign param_valid_out     = s.param_valid;
   assign param_data_out      = s.param_data;
   assign param_index_out     = s.param_index;
   assign gate_high_level_out = s.gate_code;
   assign gate_half_volts_out = s.gate_half_v;

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   property p_cs_gate;
      s.cs_s[1] |=> s.bit_cnt == 4'h0 && !cmd_valid_out && !param_valid_out;
   endproperty
   a_cs_gate: assert property (p_cs_gate) else $error("bits taken with select high");

   property p_cmd_kind;
      cmd_valid_out |-> cmd_code_out == s.shift[7:0] &&
                        (s.three_wire ? !s.shift[8] : !$past(s.dc_s[1]));
   endproperty
   a_cmd_kind: assert property (p_cmd_kind) else $error("command code mismatch");

   property p_dc_split;
      !(cmd_valid_out && param_valid_out);
   endproperty
   a_dc_split: assert property (p_dc_split) else $error("byte both command and data");

   property p_pin_reset;
      !s.rstp_s[1] |=> gate_high_level_out == epc_pkg::GATE_CODE_DEFAULT &&
                       cmd_code_out == epc_pkg::CMD_RESET && !cmd_valid_out;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("reset pin not obeyed");

   property p_busy;
      busy_out == $past(s.work_s[1]);
   endproperty
   a_busy: assert property (p_busy) else $error("busy not following work");

   property p_variant;
      (cmd_valid_out || param_valid_out) |->
         $past(s.bit_cnt) == (s.three_wire ? 4'h8 : 4'h7);
   endproperty
   a_variant: assert property (p_variant) else $error("wrong word length");

   property p_gate;
      param_valid_out && cmd_code_out == epc_pkg::CMD_GATE_LEVEL &&
      param_index_out == 8'h01 && param_data_out[4:0] >= epc_pkg::GATE_CODE_MIN &&
      param_data_out[4:0] <= epc_pkg::GATE_CODE_MAX
      |-> gate_high_level_out == param_data_out[4:0] &&
          gate_half_volts_out == {1'b0, param_data_out[4:0]} + 6'h11;
   endproperty
   a_gate: assert property (p_gate) else $error("gate level not applied");

   property p_order;
      param_valid_out |-> param_index_out == $past(param_index_out) + 8'h01 ||
                          $past(param_index_out) == 8'hff;
   endproperty
   a_order: assert property (p_order) else $error("parameter order broken");

   property p_restart;
      cmd_valid_out |-> param_index_out == 8'h00;
   endproperty
   a_restart: assert property (p_restart) else $error("index not restarted");

   c_cmd: cover property (cmd_valid_out ##[1:400] param_valid_out);
   c_gate: cover property (cmd_valid_out && cmd_code_out == 8'h03 ##[1:400] param_valid_out);
   c_three: cover property (s.three_wire && cmd_valid_out);
   c_busy: cover property ($rose(busy_out) ##[1:100] $fell(busy_out));

endmodule : epc_host_cmd_port

`default_nettype wire

/* File: verif/epc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// host side of the link
module epc_host_model (
   input  wire logic sys_clk_in,
   input  wire logic busy_in,
   input  wire logic three_in,
   output logic      clk_out,
   output logic      dat_out,
   output logic      cs_low_out,
   output logic      dc_out
);
   initial
   begin
      clk_out = 1'b0;
      dat_out = 1'b0;
      cs_low_out = 1'b1;
      dc_out = 1'b0;
   end
   // n below the word width drops the frame early
   task automatic send(input logic dc, input logic [7:0] b, input int n);
      logic [8:0] w;
      int         i;
      w = three_in ? {dc, b} : {b, 1'b0};
      for (i = 0; i < 1000 && busy_in !== 1'b0; i++)
         @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      #1 cs_low_out = 1'b0;
      dc_out = three_in ? ~dc : dc;
      for (i = 0; i < n; i++)
      begin
         dat_out = w[8 - i];
         #62.5 clk_out = 1'b1;
         #62.5 clk_out = 1'b0;
      end
      #62.5 cs_low_out = 1'b1;
      // released lines show no stale value
      dat_out = ~dat_out;
      dc_out = ~dc_out;
      // select must stay high long enough for the two-flop sampler to see it
      repeat (4) @(negedge sys_clk_in);
   endtask : send
endmodule : epc_host_model
`default_nettype wire

/* File: verif/epc_host_cmd_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module epc_host_cmd_port_tb_top;
   logic       sys_clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       rpin = 1'b1;
   logic       strap = 1'b0;
   logic       work = 1'b0;
   logic       lclk, ldat, lcs, ldc, busy, tw, cv, pv;
   logic [7:0] code, pdat, pidx;
   logic [4:0] gl;
   logic [5:0] ghv;
   int         mismatches = 0;
   int         checks = 0;
   int         cyc = 0;
   int         ncmd = 0;
   int         nprm = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   epc_host_model epc_host_model_i (.sys_clk_in(sys_clk_in), .busy_in(busy), .three_in(strap),
      .clk_out(lclk), .dat_out(ldat), .cs_low_out(lcs), .dc_out(ldc));
   epc_host_cmd_port epc_host_cmd_port_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .link_clk_in(lclk), .link_data_in(ldat), .link_cs_low_in(lcs), .link_dc_in(ldc),
      .reset_low_pin_in(rpin), .link_variant_strap_in(strap), .work_in(work),
      .busy_out(busy), .three_wire_out(tw), .cmd_valid_out(cv), .cmd_code_out(code),
      .param_valid_out(pv), .param_data_out(pdat), .param_index_out(pidx),
      .gate_high_level_out(gl), .gate_half_volts_out(ghv));
   // =====
   // pulse counters and hang limit
   always @(posedge sys_clk_in)
   begin
      cyc <= cyc + 1;
      ncmd <= ncmd + int'(cv === 1'b1);
      nprm <= nprm + int'(pv === 1'b1);
   end
   always @(posedge sys_clk_in)
      if (cyc == 20000) end_sim(1'b1);
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one byte, then exactly one pulse of the right kind
   task automatic xfer(input logic dc, input logic [7:0] b);
      int c0;
      int p0;
      c0 = ncmd;
      p0 = nprm;
      epc_host_model_i.send(dc, b, strap ? 9 : 8);
      repeat (4) @(negedge sys_clk_in);
      chk("cmd pulses", 8'(c0 + int'(!dc)), 8'(ncmd));
      chk("param pulses", 8'(p0 + int'(dc)), 8'(nprm));
      chk("byte", b, dc ? pdat : code);
   endtask : xfer
   task automatic t_params();
      xfer(1'b0, 8'h03);
      chk("index cmd", 8'h00, pidx);
      xfer(1'b1, 8'h05);
      chk("index 1", 8'h01, pidx);
      xfer(1'b1, 8'h0a);
      chk("index 2", 8'h02, pidx);
      xfer(1'b0, 8'h01);
      chk("index new", 8'h00, pidx);
   endtask : t_params
   task automatic t_gate();
      logic [4:0] cd [7] = '{5'h00, 5'h03, 5'h01, 5'h17, 5'h18, 5'h0d, 5'h02};
      logic [4:0] lv;
      lv = epc_pkg::GATE_CODE_DEFAULT;
      foreach (cd[i])
      begin
         xfer(1'b0, epc_pkg::CMD_GATE_LEVEL);
         // top bits set: only the low five count
         xfer(1'b1, {3'h7, cd[i]});
         if (cd[i] == 5'h00 || (cd[i] >= 5'h03 && cd[i] <= 5'h17)) lv = cd[i];
         chk("gate", {3'h0, lv}, {3'h0, gl});
         chk("half volts", {2'h0, lv == 5'h00 ? 6'h28 : {1'b0, lv} + 6'h11}, {2'h0, ghv});
      end
   endtask : t_gate
   task automatic t_other();
      int c0;
      c0 = ncmd + nprm;
      epc_host_model_i.send(1'b0, 8'hff, 5);
      repeat (4) @(negedge sys_clk_in);
      chk("partial pulses", 8'(c0), 8'(ncmd + nprm));
      xfer(1'b0, 8'h12);
      strap = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      chk("three wire", 8'h01, {7'h0, tw});
      xfer(1'b0, 8'h03);
      xfer(1'b1, 8'h15);
      chk("gate 3-line", 8'h15, {3'h0, gl});
      strap = 1'b0;
      work = 1'b1;
      repeat (5) @(negedge sys_clk_in);
      chk("busy high", 8'h01, {7'h0, busy});
      fork
         #500 work = 1'b0;
      join_none
      xfer(1'b0, 8'h22);
      chk("busy low", 8'h00, {7'h0, busy});
      chk("three wire off", 8'h00, {7'h0, tw});
      rpin = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      chk("code pin reset", 8'h00, code);
      chk("gate pin reset", 8'h00, {3'h0, gl});
      rpin = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      xfer(1'b0, 8'h03);
   endtask : t_other
   task automatic end_sim(input bit tmo);
      mismatches += int'(tmo);
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (20) @(negedge sys_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      chk("half volts rst", 8'h28, {2'h0, ghv});
      t_params();
      t_gate();
      t_other();
      end_sim(1'b0);
   end
endmodule : epc_host_cmd_port_tb_top
`default_nettype wire
